// ---- flash_seq_pkg.sv ----
// Constants shared by the self-programming flash sequencer and its buffer.
// Assumes a 100 MHz system clock and a 24-bit program memory address.
`default_nettype none

package flash_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_CTRL = 8'h00;     // flash_control_reg
  localparam logic [7:0] OFF_KEY = 8'h04;      // unlock_key_reg, write only
  localparam logic [7:0] OFF_TBL_PAGE = 8'h08; // table_page_pointer
  localparam logic [7:0] OFF_TBL_OFFS = 8'h0c; // Table write address, low 16 bits
  localparam logic [7:0] OFF_TBL_LO = 8'h10;   // table_write_low_op data
  localparam logic [7:0] OFF_TBL_HI = 8'h14;   // table_write_high_op data
  localparam logic [7:0] OFF_LAST_ADDR = 8'h18; // Captured target address
  localparam logic [7:0] OFF_STATUS = 8'h1c;   // Busy and pending reset

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int BIT_START = 15;       // Operation start bit
  localparam int BIT_PROG_EN = 14;     // program_enable_bit
  localparam int BIT_SEQ_ERR = 13;     // sequence_error_flag
  localparam int BIT_ERASE_SEL = 6;    // Erase / program select
  localparam int OP_MSB = 3;           // flash_op_code msb
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Operation codes
  localparam logic [3:0] OPC_PAGE_ERASE = 4'h2;
  localparam logic [3:0] OPC_WORD_PROG = 4'h3;
  localparam logic [3:0] OPC_ROW_PROG = 4'h1;

  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int ROW_WORDS = 64;       // Instruction words per row
  localparam int BUF_IDX_W = 6;        // Holding buffer index width
  localparam int ADDR_W = 24;          // Program address width
  localparam int ROW_ADDR_BITS = 7;    // Buffer select bits, ignored for row
  localparam int PAGE_ADDR_BITS = 10;  // Ignored for page erase
  localparam int WORD_W = 24;          // Instruction word width

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed operation durations
  localparam int CLK_MHZ = 100;
  localparam int WORD_PROG_TIME_US = 20;
  localparam int ROW_PROG_TIME_US = 1600;
  localparam int PAGE_ERASE_TIME_US = 20000;
  localparam int WORD_PROG_CYCLES = WORD_PROG_TIME_US * CLK_MHZ;
  localparam int ROW_PROG_CYCLES = ROW_PROG_TIME_US * CLK_MHZ;
  localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_US * CLK_MHZ;

  // Operation kinds
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_ERASE,
    KIND_WORD,
    KIND_ROW
  } op_kind_e;

  // Decode erase select and op code into an operation
  function automatic op_kind_e decode_op(input logic erase_sel, input logic [3:0] code,
                                         input logic multi);
    op_kind_e kind;
    kind = KIND_NONE;
    if (erase_sel) begin
      if (code == OPC_PAGE_ERASE) begin
        kind = KIND_ERASE;
      end
    end else if (code == OPC_WORD_PROG) begin
      kind = KIND_WORD;
    end else if ((code == OPC_ROW_PROG) && multi) begin
      kind = KIND_ROW;
    end
    return kind;
  endfunction : decode_op

  // Holding buffer selected by a table write address
  function automatic logic [BUF_IDX_W-1:0] buf_index(input logic [ADDR_W-1:0] addr,
                                                     input logic multi);
    return multi ? addr[ROW_ADDR_BITS-1:1] : '0;
  endfunction : buf_index

  // Clear the low address bits that an operation ignores
  function automatic logic [ADDR_W-1:0] align_down(input logic [ADDR_W-1:0] addr,
                                                   input int bits);
    logic [ADDR_W-1:0] mask;
    mask = '1;
    mask = mask << bits;
    return addr & mask;
  endfunction : align_down

endpackage : flash_seq_pkg

`default_nettype wire

// ---- program_word_buffer.sv ----
// Holding buffers between table writes and flash programming.
// Assumes writes and reads on the system clock; contents have no reset.
`default_nettype none

module program_word_buffer
  import flash_seq_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Write side
  input wire logic i_wr_lo,
  input wire logic i_wr_hi,
  input wire logic [BUF_IDX_W-1:0] i_wr_index,
  input wire logic [15:0] i_wr_data,
  // Read side
  input wire logic [BUF_IDX_W-1:0] i_rd_index,
  output logic [WORD_W-1:0] o_rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // One instruction word per holding buffer
  logic [WORD_W-1:0] words [ROW_WORDS];

  // Low 16 bits and high byte load separately; old data stays until replaced
  always_ff @(posedge i_clk) begin
    if (i_wr_lo) begin
      words[i_wr_index][15:0] <= i_wr_data;
    end
    if (i_wr_hi) begin
      words[i_wr_index][WORD_W-1:16] <= i_wr_data[7:0];
    end
  end

  // Asynchronous read of the selected buffer
  assign o_rd_data = words[i_rd_index];

endmodule : program_word_buffer

`default_nettype wire

// ---- flash_sequencer.sv ----
// Self-programming flash sequencer: APB registers, unlock, table writes, timing.
// Assumes I_RST_B is the power-on / brown-out reset and an array that takes
// one word per write strobe and runs erase and program while its level is high.
//
// How it works
// - Rows hold 64 words of 192 bytes
// - Page erase clears eight rows together
// - Pages and rows aligned from memory start
// - Multi variant holds 64 word buffers
// - Single variant programs one word only
// - Last table write chooses target row
// - Table writes fill buffers, two cycles
// - Start bit launches op, self-clears
// - Core stalled until operation ends
// - Power-on or brown-out reset aborts operation
// - Other resets wait for operation end
// - Erase ignores ten low address bits
// - Seven low bits pick buffer, any order
// - Row program ignores buffer select bits
// - Keys open one-transfer control window
// - Op code with erase select picks operation
// - Enable bit gates, erase bit selects
// - Error flag on start without unlock or enable bit; unknown op code not flagged
`default_nettype none

module flash_sequencer
  import flash_seq_pkg::*;
#(
  parameter bit MULTI_BUFFER = 1'b1,
  parameter int WORD_CYCLES = WORD_PROG_CYCLES,
  parameter int ROW_CYCLES = ROW_PROG_CYCLES,
  parameter int ERASE_CYCLES = PAGE_ERASE_CYCLES
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  // Other reset sources, held until flash is idle
  input wire logic I_OTHER_RESET_REQ,
  output logic O_OTHER_RESET,
  // Core stall
  output logic O_CORE_STALL,
  // Flash array
  output logic [ADDR_W-1:0] O_FLASH_ADDR,
  output logic [WORD_W-1:0] O_FLASH_DATA,
  output logic O_FLASH_WE,
  output logic O_FLASH_PROG,
  output logic O_FLASH_ERASE
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_STREAM,
    SEQ_TIMED
  } seq_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  seq_state_e state;                 // Sequencer state
  logic [31:0] timer;                // Remaining timed cycles
  logic [BUF_IDX_W-1:0] idx;         // Buffer being streamed
  logic stream_row;                  // Streaming a whole row
  logic start_bit;                   // Start bit, hardware cleared
  logic prog_en;                     // program_enable_bit
  logic seq_err;                     // sequence_error_flag
  logic erase_sel;                   // Erase / program select
  logic [3:0] op_code;               // flash_op_code
  logic key_armed;                   // First key seen
  logic unlock_window;               // Start of an operation allowed
  logic [7:0] tbl_page;              // table_page_pointer
  logic [15:0] tbl_offs;             // Table address offset
  logic [ADDR_W-1:0] last_addr;      // Most recent table write address
  logic tbl_wait;                    // Extra cycle of a table write
  logic reset_pending;               // Held other reset

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Access phase: select and enable both high
  wire access = I_PSEL & I_PENABLE;
  wire xfer_done = access & O_PREADY;
  wire sel_ctrl = (I_PADDR == OFF_CTRL);
  wire sel_key = (I_PADDR == OFF_KEY);
  wire sel_page = (I_PADDR == OFF_TBL_PAGE);
  wire sel_offs = (I_PADDR == OFF_TBL_OFFS);
  wire sel_lo = (I_PADDR == OFF_TBL_LO);
  wire sel_hi = (I_PADDR == OFF_TBL_HI);
  wire sel_last = (I_PADDR == OFF_LAST_ADDR);
  wire sel_stat = (I_PADDR == OFF_STATUS);
  wire mapped = sel_ctrl | sel_key | sel_page | sel_offs | sel_lo | sel_hi | sel_last
                | sel_stat;
  wire wr_done = xfer_done & I_PWRITE & mapped;
  wire is_tbl_wr = I_PWRITE & (sel_lo | sel_hi);
  wire busy = O_CORE_STALL;

  // core stall, no answer while busy
  wire ready_now = access & ~O_PREADY & ~busy & (~is_tbl_wr | tbl_wait);

  ////////////////////////////////////////////////////////////////////////////
  // Table write decode
  wire [ADDR_W-1:0] tbl_addr = {tbl_page, tbl_offs};
  wire tbl_lo_wr = wr_done & sel_lo;
  wire tbl_hi_wr = wr_done & sel_hi;
  wire [BUF_IDX_W-1:0] tbl_idx = buf_index(tbl_addr, MULTI_BUFFER);

  ////////////////////////////////////////////////////////////////////////////
  // Control write and start decode
  wire ctrl_wr = wr_done & sel_ctrl;
  wire start_try = ctrl_wr & I_PWDATA[BIT_START];
  wire start_ok = start_try & unlock_window & I_PWDATA[BIT_PROG_EN];
  wire op_kind_e kind = decode_op(I_PWDATA[BIT_ERASE_SEL], I_PWDATA[OP_MSB:0],
                                  MULTI_BUFFER);
  wire launch = start_ok & (kind != KIND_NONE);
  wire timed_end = (state == SEQ_TIMED) & (timer == 32'h0000_0001);
  wire err_set = start_try & ~start_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Addresses for the array
  // row address ignores buffer bits
  wire [ADDR_W-1:0] row_base = align_down(last_addr, ROW_ADDR_BITS);
  wire [ADDR_W-1:0] page_base = align_down(last_addr, PAGE_ADDR_BITS);
  wire [BUF_IDX_W-1:0] word_idx = buf_index(last_addr, MULTI_BUFFER);
  wire [ADDR_W-1:0] word_addr = align_down(last_addr, 1);
  wire [ADDR_W-1:0] stream_addr = row_base | {{(ADDR_W-BUF_IDX_W-1){1'b0}}, idx, 1'b0};
  wire stream_last = ~stream_row | (idx == BUF_IDX_W'(ROW_WORDS - 1));
  wire [WORD_W-1:0] buf_data;

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux
  wire [15:0] ctrl_view = {start_bit, prog_en, seq_err, 6'h00, erase_sel, 2'h0, op_code};
  wire [31:0] rd_mux = sel_ctrl ? {16'h0000, ctrl_view} :
                       sel_page ? {24'h00_0000, tbl_page} :
                       sel_offs ? {16'h0000, tbl_offs} :
                       sel_last ? {8'h00, last_addr} :
                       sel_stat ? {30'h0000_0000, reset_pending, busy} :
                       32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // holding buffers for one row
  program_word_buffer u_buffer (
    .i_clk(I_CLOCK),
    .i_wr_lo(tbl_lo_wr),
    .i_wr_hi(tbl_hi_wr),
    .i_wr_index(tbl_idx),
    .i_wr_data(I_PWDATA[15:0]),
    .i_rd_index(idx),
    .o_rd_data(buf_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, two for table writes
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
      tbl_wait <= 1'b0;
    end else begin
      O_PREADY <= ready_now;
      O_PSLVERR <= ready_now & ~mapped;
      tbl_wait <= access & is_tbl_wr & ~busy & ~O_PREADY;
      // Read data captured with the answer
      if (ready_now) begin
        O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key tracking; any completed transfer closes the window
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      key_armed <= 1'b0;
      unlock_window <= 1'b0;
    end else if (xfer_done) begin
      key_armed <= wr_done & sel_key & (I_PWDATA[7:0] == KEY_FIRST);
      unlock_window <= wr_done & sel_key & key_armed & (I_PWDATA[7:0] == KEY_SECOND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table address and target capture
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tbl_page <= 8'h00;
      tbl_offs <= 16'h0000;
      last_addr <= '0;
    end else begin
      if (wr_done & sel_page) begin
        tbl_page <= I_PWDATA[7:0];
      end
      if (wr_done & sel_offs) begin
        tbl_offs <= I_PWDATA[15:0];
      end
      if (tbl_lo_wr | tbl_hi_wr) begin
        last_addr <= tbl_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      start_bit <= CTRL_RESET[BIT_START];
      prog_en <= CTRL_RESET[BIT_PROG_EN];
      seq_err <= CTRL_RESET[BIT_SEQ_ERR];
      erase_sel <= CTRL_RESET[BIT_ERASE_SEL];
      op_code <= CTRL_RESET[OP_MSB:0];
    end else begin
      // Configuration fields are writable at any time outside an operation
      if (ctrl_wr) begin
        prog_en <= I_PWDATA[BIT_PROG_EN];
        erase_sel <= I_PWDATA[BIT_ERASE_SEL];
        op_code <= I_PWDATA[OP_MSB:0];
      end
      // start set by launch, cleared at end
      if (launch) begin
        start_bit <= 1'b1;
      end else if (timed_end) begin
        start_bit <= 1'b0;
      end
      if (err_set) begin
        seq_err <= 1'b1;
      end else if (timed_end) begin
        seq_err <= 1'b0;
      end else if (ctrl_wr) begin
        seq_err <= I_PWDATA[BIT_SEQ_ERR];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state <= SEQ_IDLE;
      timer <= 32'h0000_0000;
      idx <= '0;
      stream_row <= 1'b0;
      O_CORE_STALL <= 1'b0;
      O_FLASH_ADDR <= '0;
      O_FLASH_DATA <= '0;
      O_FLASH_WE <= 1'b0;
      O_FLASH_PROG <= 1'b0;
      O_FLASH_ERASE <= 1'b0;
    end else begin
      O_FLASH_WE <= 1'b0;
      case (state)
        SEQ_IDLE: begin
          // nothing starts without a valid launch
          if (launch) begin
            O_CORE_STALL <= 1'b1;
            if (kind == KIND_ERASE) begin
              state <= SEQ_TIMED;
              timer <= 32'(ERASE_CYCLES);
              O_FLASH_ADDR <= page_base;
              O_FLASH_ERASE <= 1'b1;
            end else begin
              state <= SEQ_STREAM;
              stream_row <= (kind == KIND_ROW);
              idx <= (kind == KIND_ROW) ? '0 : word_idx;
            end
          end
        end
        SEQ_STREAM: begin
          // One buffer word per cycle to the array
          O_FLASH_WE <= 1'b1;
          O_FLASH_DATA <= buf_data;
          O_FLASH_ADDR <= stream_row ? stream_addr : word_addr;
          idx <= idx + BUF_IDX_W'(1);
          if (stream_last) begin
            state <= SEQ_TIMED;
            timer <= stream_row ? 32'(ROW_CYCLES) : 32'(WORD_CYCLES);
            O_FLASH_PROG <= 1'b1;
          end
        end
        SEQ_TIMED: begin
          timer <= timer - 32'h0000_0001;
          if (timed_end) begin
            state <= SEQ_IDLE;
            O_CORE_STALL <= 1'b0;
            O_FLASH_PROG <= 1'b0;
            O_FLASH_ERASE <= 1'b0;
          end
        end
        default: begin
          state <= SEQ_IDLE;
          O_CORE_STALL <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Other resets held while the array is busy
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      reset_pending <= 1'b0;
      O_OTHER_RESET <= 1'b0;
    end else begin
      O_OTHER_RESET <= reset_pending & ~busy & ~O_OTHER_RESET;
      if (I_OTHER_RESET_REQ) begin
        reset_pending <= 1'b1;
      end else if (O_OTHER_RESET) begin
        reset_pending <= 1'b0;
      end
    end
  end

endmodule : flash_sequencer

`default_nettype wire

// ---- flash_seq_sva.sv ----
// Port checker for the flash sequencer, bound into every instance.
// Assumes one clock domain with I_RST_B as its only reset.
`default_nettype none
module flash_seq_sva
  import flash_seq_pkg::*;
#(
  parameter int WORD_CYCLES = 4,
  parameter int ROW_CYCLES = 8,
  parameter int ERASE_CYCLES = 16
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // Watched outputs
  input wire logic O_PREADY,
  input wire logic O_OTHER_RESET,
  input wire logic O_CORE_STALL,
  input wire logic [ADDR_W-1:0] O_FLASH_ADDR,
  input wire logic O_FLASH_WE,
  input wire logic O_FLASH_PROG,
  input wire logic O_FLASH_ERASE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);
  int we_run; // Strobes in the current burst
  int prog_len; // Cycles of program timing
  int erase_len; // Cycles of erase timing
  ////////////////////////////////////////
  // Run length counters
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      we_run <= 0;
      prog_len <= 0;
      erase_len <= 0;
    end else begin
      we_run <= O_FLASH_WE ? we_run + 1 : 0;
      prog_len <= O_FLASH_PROG ? prog_len + 1 : 0;
      erase_len <= O_FLASH_ERASE ? erase_len + 1 : 0;
    end
  end
  // End of timing and end of a write burst
  sequence s_timing_end;
    $fell(O_FLASH_PROG) || $fell(O_FLASH_ERASE);
  endsequence
  sequence s_burst_end;
    $fell(O_FLASH_WE);
  endsequence
  ////////////////////////////////////////
  a_stall_bus: assert property (O_CORE_STALL |-> !O_PREADY)
    else $error("bus answered during stall");
  a_we_stall: assert property (O_FLASH_WE |-> O_CORE_STALL)
    else $error("array strobe outside stall");
  a_time_stall: assert property ((O_FLASH_PROG || O_FLASH_ERASE) |-> O_CORE_STALL)
    else $error("timing outside stall");
  a_burst_size: assert property (s_burst_end |-> (we_run == 1 || we_run == ROW_WORDS))
    else $error("write burst of wrong length");
  a_row_step: assert property ((O_FLASH_WE && $past(O_FLASH_WE)) |->
    (O_FLASH_ADDR == $past(O_FLASH_ADDR) + 24'h2 && O_FLASH_ADDR[6:0] != 7'h0))
    else $error("row address step wrong");
  a_prog_after: assert property (s_burst_end |-> O_FLASH_PROG)
    else $error("no program timing after burst");
  a_prog_time: assert property ($fell(O_FLASH_PROG) |->
    (prog_len == WORD_CYCLES || prog_len == ROW_CYCLES))
    else $error("program time wrong");
  a_erase_time: assert property ($fell(O_FLASH_ERASE) |-> erase_len == ERASE_CYCLES)
    else $error("erase time wrong");
  a_erase_align: assert property (O_FLASH_ERASE |-> O_FLASH_ADDR[PAGE_ADDR_BITS-1:0] == '0)
    else $error("erase address not page aligned");
  a_end_together: assert property (s_timing_end |-> $fell(O_CORE_STALL))
    else $error("stall did not end with timing");
  a_reset_held: assert property (O_OTHER_RESET |-> !O_CORE_STALL)
    else $error("held reset released during operation");
endmodule : flash_seq_sva
bind flash_sequencer flash_seq_sva #(.WORD_CYCLES(WORD_CYCLES), .ROW_CYCLES(ROW_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) flash_seq_sva_inst (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B),
  .O_PREADY(O_PREADY), .O_OTHER_RESET(O_OTHER_RESET), .O_CORE_STALL(O_CORE_STALL),
  .O_FLASH_ADDR(O_FLASH_ADDR), .O_FLASH_WE(O_FLASH_WE), .O_FLASH_PROG(O_FLASH_PROG),
  .O_FLASH_ERASE(O_FLASH_ERASE));
`default_nettype wire

// ---- flash_array_model.sv ----
// Flash array model facing the sequencer's array outputs.
// Assumes word addresses in steps of two; erased cells read all ones.
`default_nettype none
module flash_array_model
  import flash_seq_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Array strobes from the sequencer
  input wire logic i_we,
  input wire logic i_erase,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [WORD_W-1:0] i_data,
  // Bench read back
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [WORD_W-1:0] o_rd_data,
  output logic [15:0] o_we_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_W-1:0] mem [int]; // Programmed cells only
  logic erase_seen = 1'b0; // Erase level one cycle ago
  initial o_we_count = '0;
  ////////////////////////////////////////
  // page cleared at erase start, words stored on strobe
  always @(posedge i_clk) begin
    erase_seen <= i_erase;
    o_rd_data <= mem.exists(i_rd_addr) ? mem[i_rd_addr] : '1;
    if (i_we) begin
      mem[i_addr] = i_data;
      o_we_count <= o_we_count + 16'h1;
    end
    if (i_erase && !erase_seen) begin
      for (int i = 0; i < 1024; i++) begin
        mem.delete(i_addr + i);
      end
    end
  end
endmodule : flash_array_model
`default_nettype wire

// ---- tb_self_program_flash_sequencer.sv ----
// Self-checking bench: APB master, array model and expected buffers.
// Assumes shortened timing parameters and one 100 MHz clock.
`default_nettype none
module tb_self_program_flash_sequencer
  import flash_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] RB = 24'h020080; // Row aligned target
  logic clock = 1'b0; // System clock
  logic rst_b = 1'b0; // Power-on reset
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB enable
  logic pwrite = 1'b0; // APB direction
  logic [7:0] paddr = '0; // APB address
  logic [31:0] pwdata = '0; // APB write data
  logic other_req = 1'b0; // Deferred reset request
  logic [23:0] m_addr = '0; // Array read back address
  logic pready, pslverr, other_rst, stall, f_we, f_prog, f_erase;
  logic [31:0] prdata, rd;
  logic [23:0] f_addr, f_data, m_data;
  logic [15:0] we_cnt, n0;
  logic [15:0] rs = 16'ha74d; // Random state
  logic [23:0] buf_m [ROW_WORDS]; // Expected holding buffers
  logic err; // Last error response
  int fails = 0;
  int n_compared = 0;
  int n_other = 0; // Released resets seen
  int lat; // Answer delay in cycles
  ////////////////////////////////////////
  // Free running clock
  always #5 clock = ~clock;
  flash_sequencer #(.WORD_CYCLES(4), .ROW_CYCLES(8), .ERASE_CYCLES(16)) flash_sequencer_inst (
    .I_CLOCK(clock), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr), .I_OTHER_RESET_REQ(other_req),
    .O_OTHER_RESET(other_rst), .O_CORE_STALL(stall), .O_FLASH_ADDR(f_addr),
    .O_FLASH_DATA(f_data), .O_FLASH_WE(f_we), .O_FLASH_PROG(f_prog), .O_FLASH_ERASE(f_erase));
  flash_array_model flash_array_model_inst (.i_clk(clock), .i_we(f_we), .i_erase(f_erase),
    .i_addr(f_addr), .i_data(f_data), .i_rd_addr(m_addr), .o_rd_data(m_data),
    .o_we_count(we_cnt));
  // Count released resets
  always @(posedge clock) begin
    if (other_rst === 1'b1) begin
      n_other <= n_other + 1;
    end
  end
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    lat = k;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : apb
  // Table write of one word; buffer picked by address
  task automatic tw(input logic [23:0] a, input logic [23:0] d);
    apb(1, OFF_TBL_PAGE, {24'h0, a[23:16]});
    apb(1, OFF_TBL_OFFS, {16'h0, a[15:0]});
    apb(1, OFF_TBL_LO, {16'h0, d[15:0]});
    chk(lat, 3);
    apb(1, OFF_TBL_HI, {24'h0, d[23:16]});
    buf_m[a[6:1]] = d;
  endtask : tw
  task automatic keys();
    apb(1, OFF_KEY, {24'h0, KEY_FIRST});
    apb(1, OFF_KEY, {24'h0, KEY_SECOND});
  endtask : keys
  task automatic go(input logic [31:0] c);
    apb(1, OFF_CTRL, c);
    keys();
    apb(1, OFF_CTRL, c | 32'h8000);
  endtask : go
  task automatic mchk(input logic [23:0] a, input logic [23:0] e);
    m_addr <= a;
    repeat (2) @(posedge clock);
    chk(m_data, e);
  endtask : mchk
  ////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end
  // Main sequence
  initial begin
    logic [23:0] a, d;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    apb(0, OFF_CTRL, '0);
    chk(rd, {16'h0, CTRL_RESET});
    chk(lat, 2);
    apb(0, OFF_STATUS, '0);
    chk(rd, '0);
    apb(1, 8'h40, '1);
    chk(err, 1'b1);
    apb(0, 8'h40, '0);
    chk(rd, '0);
    $display("test registers done");
    rs = lfsr(rs);
    a = {8'h01, rs[15:1], 1'b1};
    d = {rs[7:0], lfsr(rs)};
    n0 = we_cnt;
    tw(a, d);
    apb(0, OFF_LAST_ADDR, '0);
    chk(rd, {8'h0, a});
    go(32'h4003);
    #1;
    chk(stall, 1'b1);
    apb(0, OFF_CTRL, '0);
    chk(rd, 32'h4003);
    chk(we_cnt - n0, 1);
    mchk(a & 24'hfffffe, d);
    $display("test word program done");
    for (int c = 0; c < 4; c++) begin
      n0 = we_cnt;
      apb(1, OFF_CTRL, 32'h4003);
      if (c > 0) begin
        keys();
      end
      if (c == 1) begin
        apb(0, OFF_STATUS, '0);
      end
      apb(1, OFF_CTRL, (c == 2) ? 32'h8003 : (c == 3) ? 32'hc002 : 32'hc003);
      #1;
      chk(stall, 1'b0);
      apb(0, OFF_CTRL, '0);
      chk(rd, (c == 2) ? 32'h2003 : (c == 3) ? 32'h4002 : 32'h6003);
      chk(we_cnt - n0, 0);
    end
    $display("test refused starts done");
    rs = lfsr(rs);
    a = {8'h03, rs};
    // each location programmed once per erase
    for (int k = 0; k < 2; k++) begin
      tw((a & 24'hfffc00) + 24'h100 + 24'(k * 1024), d);
      go(32'h4003);
    end
    tw(a, d);
    go(32'h4042);
    @(posedge clock);
    other_req <= 1'b1;
    @(posedge clock);
    other_req <= 1'b0;
    chk(n_other, 0);
    apb(0, OFF_CTRL, '0);
    chk(rd, 32'h4042);
    mchk((a & 24'hfffc00) + 24'h100, 24'hffffff);
    mchk((a & 24'hfffc00) + 24'h500, d);
    chk(n_other, 1);
    $display("test page erase done");
    // full row loaded out of order
    for (int i = 0; i < ROW_WORDS; i++) begin
      rs = lfsr(rs);
      tw(RB + 24'((i * 37) % 64 * 2), {rs[7:0], lfsr(rs)});
    end
    for (int r = 0; r < 2; r++) begin
      if (r == 1) begin
        rs = lfsr(rs);
        tw(RB + 24'h8a, {8'h5a, rs});
      end
      n0 = we_cnt;
      go(32'h4001);
      apb(0, OFF_CTRL, '0);
      chk(rd, 32'h4001);
      chk(we_cnt - n0, ROW_WORDS);
      for (int i = 0; i < ROW_WORDS; i++) begin
        mchk(RB + 24'(128 * r + 2 * i), buf_m[i]);
      end
    end
    $display("test row program done");
    go(32'h4001);
    repeat (3) @(posedge clock);
    chk(stall, 1'b1);
    rst_b <= 1'b0;
    @(posedge clock);
    chk({stall, f_we, f_prog}, 3'b000);
    rst_b <= 1'b1;
    apb(0, OFF_CTRL, '0);
    chk(rd, 32'h0);
    $display("test abort done");
    complete_run();
  end
endmodule : tb_self_program_flash_sequencer
`default_nettype wire
